// >>> src/rtcal_cfg.svh
`ifndef RTCAL_CFG_SVH
`define RTCAL_CFG_SVH

// Register byte addresses
`define RTCAL_ADDR_A1_SECOND   8'h08
`define RTCAL_ADDR_A1_MINUTE   8'h09
`define RTCAL_ADDR_A1_HOUR     8'h0A
`define RTCAL_ADDR_A1_DAY      8'h0B
`define RTCAL_ADDR_A1_MONTH    8'h0C
`define RTCAL_ADDR_A2_MINUTE   8'h0D
`define RTCAL_ADDR_A2_HOUR     8'h0E
`define RTCAL_ADDR_A2_WEEKDAY  8'h0F
`define RTCAL_ADDR_ENABLES     8'h10
`define RTCAL_ADDR_FIRST       8'h08
`define RTCAL_ADDR_LAST        8'h10
`define RTCAL_NUM_REGS         9
`define RTCAL_IDX_ENABLES      4'h8

// Reset values
`define RTCAL_RST_SETTING      8'h00
`define RTCAL_RST_ENABLES      8'h00
`define RTCAL_RDATA_UNMAPPED   8'h00

// Field enable bit positions in the enable register
`define RTCAL_BIT_A2_WEEKDAY   7
`define RTCAL_BIT_A2_HOUR      6
`define RTCAL_BIT_A2_MINUTE    5
`define RTCAL_BIT_A1_MONTH     4
`define RTCAL_BIT_A1_DAY       3
`define RTCAL_BIT_A1_HOUR      2
`define RTCAL_BIT_A1_MINUTE    1
`define RTCAL_BIT_A1_SECOND    0
`define RTCAL_A1_EN_LSB        0
`define RTCAL_A2_EN_LSB        5
`define RTCAL_A1_FIELDS        5
`define RTCAL_A2_FIELDS        3

// Implemented bits per setting register, calendar mode
`define RTCAL_MASK_CAL_SECMIN  8'h7F
`define RTCAL_MASK_CAL_HOUR    8'h3F
`define RTCAL_MASK_CAL_DAY     8'h3F
`define RTCAL_MASK_CAL_MONTH   8'h1F
`define RTCAL_MASK_CAL_WDAY    8'h07
// Implemented bits per setting register, stop-watch mode
`define RTCAL_MASK_SW_SECMIN   8'h7F
`define RTCAL_MASK_SW_HOURS    8'hFF
`define RTCAL_MASK_ALL         8'hFF

`endif

// >>> src/rtcal_pkg.sv
package rtcal_pkg;

  // Current time from the timekeeping counters, BCD
  typedef struct packed {
    logic [7:0] second;
    logic [7:0] minute;
    logic [7:0] hour;       // Calendar hour
    logic [7:0] day;
    logic [7:0] month;
    logic [7:0] weekday;
    logic [7:0] hr_units;   // Stop-watch hours, tens and units
    logic [7:0] hr_hundreds;// Stop-watch hours, thousands and hundreds
    logic [7:0] hr_tthous;  // Stop-watch hours, hundred and ten thousands
  } rtcal_time_t;

  // Register access from the serial interface engine
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rtcal_regreq_t;

  // Interrupt output configuration
  typedef struct packed {
    logic       primary_pulse;
    logic [1:0] primary_en;   // Bit 0 alarm 1, bit 1 alarm 2
    logic       secondary_pulse;
    logic [1:0] secondary_en;
  } rtcal_irqcfg_t;

  typedef struct packed {
    logic [8:0][7:0] setting;  // Index 0 is address 08h, index 8 the enables
    logic            first_alarm_flag;
    logic            second_alarm_flag;
    logic            first_prev_match;
    logic            second_prev_match;
    logic            irq_primary;
    logic            irq_secondary;
    logic [7:0]      rdata;
  } rtcal_state_t;

endpackage

// >>> src/rtcal_field_match.sv
`timescale 1ns/1ps
module rtcal_field_match #(
  parameter int N = 5
) (
  input  wire logic [N-1:0][7:0] i_setting,  // Alarm settings per field
  input  wire logic [N-1:0][7:0] i_current,  // Current time per field
  input  wire logic [N-1:0]      i_enable,   // Field enables
  output logic                   o_match     // All enabled fields equal
);
  logic [N-1:0] hit;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_field
      assign hit[g] = ~i_enable[g] | (i_setting[g] == i_current[g]); // RULE7
    end
  endgenerate

  // No enabled field means no match at all
  assign o_match = (|i_enable) & (&hit); // RULE18
endmodule

// >>> src/rtcal_alarm.sv
// How it works
// RULE1 - Alarm 2 settings held in BCD fields
// RULE2 - Unused alarm 2 bits ignore writes
// RULE3 - Enable bits 7..5 for alarm 2, reset 0
// RULE4 - Enable bits 4..0 for alarm 1, reset 0
// RULE5 - Calendar alarm 1 compares five enabled fields
// RULE6 - Calendar alarm 2 compares minute, hour, weekday
// RULE7 - Disabled fields excluded from the comparison
// RULE8 - Full match of enabled fields sets flag
// RULE9 - Flag stays set until host clears it
// RULE10 - Match can raise an interrupt request
// RULE11 - Stop-watch alarm 1 spans seconds to 999999 hours
// RULE12 - Stop-watch alarm 2 spans minutes to 9999 hours
// RULE13 - Mode bit picks stop-watch or calendar
// RULE14 - Calendar alarm 1 fields independently enabled
// RULE15 - Interrupt is pulse per match or level
// RULE16 - After clear, flag sets on next match
// RULE17 - Flag set on entry into match only
// RULE18 - All fields disabled never sets flag
`timescale 1ns/1ps
`include "rtcal_cfg.svh"
module rtcal_alarm (
  input  wire logic                   i_ref_clk,                 // 200 MHz clock
  input  wire logic                   i_rst,                     // Synchronous reset, active high
  input  wire rtcal_pkg::rtcal_regreq_t i_reg,                   // Register access request
  input  wire logic                   i_time_tick,               // Time counters just advanced
  input  wire rtcal_pkg::rtcal_time_t i_time,                    // Current time, BCD
  input  wire logic                   i_counter_mode_select,     // 1 stop-watch, 0 calendar
  input  wire logic                   i_clear_first_alarm_flag,  // Clear command, alarm 1
  input  wire logic                   i_clear_second_alarm_flag, // Clear command, alarm 2
  input  wire rtcal_pkg::rtcal_irqcfg_t i_irq_cfg,               // Interrupt routing and mode
  output logic [7:0]                  o_reg_rdata,               // Read data, one cycle after rd
  output logic                        o_first_alarm_flag,        // Alarm 1 flag
  output logic                        o_second_alarm_flag,       // Alarm 2 flag
  output logic                        o_irq_out_primary,         // Interrupt output A
  output logic                        o_irq_out_secondary        // Interrupt output B
);

  rtcal_pkg::rtcal_state_t state_reg;
  rtcal_pkg::rtcal_state_t state_next;

  logic [`RTCAL_A1_FIELDS-1:0][7:0] a1_setting;
  logic [`RTCAL_A1_FIELDS-1:0][7:0] a1_current;
  logic [`RTCAL_A1_FIELDS-1:0]      a1_enable;
  logic [`RTCAL_A2_FIELDS-1:0][7:0] a2_setting;
  logic [`RTCAL_A2_FIELDS-1:0][7:0] a2_current;
  logic [`RTCAL_A2_FIELDS-1:0]      a2_enable;
  logic                             a1_match;
  logic                             a2_match;
  logic                             addr_hit;
  logic [3:0]                       reg_idx;

  // Implemented bits of each register for the current counter mode
  function automatic logic [7:0] field_mask(input logic [3:0] idx, input logic sw_mode);
    logic [7:0] m;
    m = `RTCAL_MASK_ALL;
    unique case (idx)
      4'h0, 4'h1, 4'h5: m = sw_mode ? `RTCAL_MASK_SW_SECMIN : `RTCAL_MASK_CAL_SECMIN;
      4'h2, 4'h6:       m = sw_mode ? `RTCAL_MASK_SW_HOURS : `RTCAL_MASK_CAL_HOUR;
      4'h3:             m = sw_mode ? `RTCAL_MASK_SW_HOURS : `RTCAL_MASK_CAL_DAY;
      4'h4:             m = sw_mode ? `RTCAL_MASK_SW_HOURS : `RTCAL_MASK_CAL_MONTH;
      4'h7:             m = sw_mode ? `RTCAL_MASK_SW_HOURS : `RTCAL_MASK_CAL_WDAY;
      default:          m = `RTCAL_MASK_ALL;
    endcase
    return m;
  endfunction

  assign addr_hit = (i_reg.addr >= `RTCAL_ADDR_FIRST) && (i_reg.addr <= `RTCAL_ADDR_LAST);
  assign reg_idx  = 4'(i_reg.addr - `RTCAL_ADDR_FIRST);

  // Alarm 1 fields: calendar second..month, stop-watch second..hundred thousands of hours
  always_comb begin
    a1_setting = state_reg.setting[4:0];
    a1_enable  = state_reg.setting[`RTCAL_IDX_ENABLES][`RTCAL_A1_EN_LSB +: `RTCAL_A1_FIELDS]; // RULE4 RULE14
    if (i_counter_mode_select) begin // RULE13
      a1_current = {i_time.hr_tthous, i_time.hr_hundreds, i_time.hr_units,
                    i_time.minute, i_time.second}; // RULE11
    end else begin
      a1_current = {i_time.month, i_time.day, i_time.hour,
                    i_time.minute, i_time.second}; // RULE5
    end
  end

  // Alarm 2 fields: calendar minute, hour, weekday; stop-watch minute and hours to 9999
  always_comb begin
    a2_setting = state_reg.setting[7:5];
    a2_enable  = state_reg.setting[`RTCAL_IDX_ENABLES][`RTCAL_A2_EN_LSB +: `RTCAL_A2_FIELDS]; // RULE3
    if (i_counter_mode_select) begin // RULE13
      a2_current = {i_time.hr_hundreds, i_time.hr_units, i_time.minute}; // RULE12
    end else begin
      a2_current = {i_time.weekday, i_time.hour, i_time.minute}; // RULE6
    end
  end

  rtcal_field_match #(
    .N (`RTCAL_A1_FIELDS)
  ) u_match_a1 (
    .i_setting (a1_setting),
    .i_current (a1_current),
    .i_enable  (a1_enable),
    .o_match   (a1_match)
  );

  rtcal_field_match #(
    .N (`RTCAL_A2_FIELDS)
  ) u_match_a2 (
    .i_setting (a2_setting),
    .i_current (a2_current),
    .i_enable  (a2_enable),
    .o_match   (a2_match)
  );

  always_comb begin
    logic entry1;
    logic entry2;
    logic [1:0] hits;
    logic [1:0] flags;
    state_next = state_reg;
    entry1     = 1'b0;
    entry2     = 1'b0;
    hits       = 2'b00;
    flags      = 2'b00;

    // Register writes; bits not implemented in the current mode are dropped
    if (i_reg.wr && addr_hit) begin
      state_next.setting[reg_idx] = i_reg.wdata & field_mask(reg_idx, i_counter_mode_select); // RULE1 RULE2
    end

    // Read data is captured one cycle after the request
    if (i_reg.rd) begin
      if (addr_hit) begin
        state_next.rdata = state_reg.setting[reg_idx] & field_mask(reg_idx, i_counter_mode_select); // RULE2
      end else begin
        state_next.rdata = `RTCAL_RDATA_UNMAPPED;
      end
    end

    // Match is sampled only when the time advances; a flag sets on the edge into it
    if (i_time_tick) begin
      entry1 = a1_match & ~state_reg.first_prev_match;  // RULE17 RULE16
      entry2 = a2_match & ~state_reg.second_prev_match; // RULE17 RULE16
      state_next.first_prev_match  = a1_match;
      state_next.second_prev_match = a2_match;
    end

    // Set wins over a clear arriving in the same cycle
    if (i_clear_first_alarm_flag) begin
      state_next.first_alarm_flag = 1'b0; // RULE9
    end
    if (i_clear_second_alarm_flag) begin
      state_next.second_alarm_flag = 1'b0; // RULE9
    end
    if (entry1) begin
      state_next.first_alarm_flag = 1'b1; // RULE8
    end
    if (entry2) begin
      state_next.second_alarm_flag = 1'b1; // RULE8
    end

    // Pulse mode fires on every new match even with the flag still set; level follows flags
    hits  = {entry2, entry1};
    flags = {state_next.second_alarm_flag, state_next.first_alarm_flag};
    state_next.irq_primary = i_irq_cfg.primary_pulse ? |(hits & i_irq_cfg.primary_en)
                                                     : |(flags & i_irq_cfg.primary_en); // RULE10 RULE15
    state_next.irq_secondary = i_irq_cfg.secondary_pulse ? |(hits & i_irq_cfg.secondary_en)
                                                         : |(flags & i_irq_cfg.secondary_en); // RULE10 RULE15
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state_reg.setting                     <= '0;
      state_reg.setting[`RTCAL_IDX_ENABLES] <= `RTCAL_RST_ENABLES; // RULE3 RULE4
      state_reg.first_alarm_flag            <= 1'b0;
      state_reg.second_alarm_flag           <= 1'b0;
      state_reg.first_prev_match            <= 1'b0;
      state_reg.second_prev_match           <= 1'b0;
      state_reg.irq_primary                 <= 1'b0;
      state_reg.irq_secondary               <= 1'b0;
      state_reg.rdata                       <= `RTCAL_RST_SETTING;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_reg_rdata         = state_reg.rdata;
  assign o_first_alarm_flag  = state_reg.first_alarm_flag;
  assign o_second_alarm_flag = state_reg.second_alarm_flag;
  assign o_irq_out_primary   = state_reg.irq_primary;
  assign o_irq_out_secondary = state_reg.irq_secondary;

endmodule

// >>> test/rtcal_alarm_sva.sv
`timescale 1ns/1ps
module rtcal_alarm_sva (
  input wire logic                    i_ref_clk,                 // Clock
  input wire logic                    i_rst,                     // Reset
  input wire rtcal_pkg::rtcal_regreq_t i_reg,                    // Register request
  input wire logic                    i_time_tick,               // Time advanced
  input wire logic                    i_clear_first_alarm_flag,  // Clear 1
  input wire logic                    i_clear_second_alarm_flag, // Clear 2
  input wire rtcal_pkg::rtcal_irqcfg_t i_irq_cfg,                // Irq setup
  input wire logic [7:0]              o_reg_rdata,               // Read data
  input wire logic                    o_first_alarm_flag,        // Flag 1
  input wire logic                    o_second_alarm_flag,       // Flag 2
  input wire logic                    o_irq_out_primary,         // Irq A
  input wire logic                    o_irq_out_secondary        // Irq B
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  a_first_flag_hold: assert property (o_first_alarm_flag && !i_clear_first_alarm_flag |=> o_first_alarm_flag)
    else $error("alarm 1 flag dropped without clear");
  a_second_flag_clear: assert property (i_clear_second_alarm_flag && !i_time_tick |=> !o_second_alarm_flag)
    else $error("alarm 2 flag not cleared");
  a_first_set_tick: assert property ($rose(o_first_alarm_flag) |-> $past(i_time_tick))
    else $error("alarm 1 flag set without tick");
  a_second_set_tick: assert property ($rose(o_second_alarm_flag) |-> $past(i_time_tick))
    else $error("alarm 2 flag set without tick");
  a_pulse_one_cycle: assert property (
    i_irq_cfg.secondary_pulse && o_irq_out_secondary |=> !o_irq_out_secondary)
    else $error("pulse irq longer than one cycle");
  a_level_follows: assert property (!i_irq_cfg.primary_pulse |-> o_irq_out_primary ==
    ((o_first_alarm_flag & i_irq_cfg.primary_en[0]) | (o_second_alarm_flag & i_irq_cfg.primary_en[1])))
    else $error("level irq does not follow flags");
  a_rdata_hold: assert property (!i_reg.rd |=> $stable(o_reg_rdata))
    else $error("read data changed without read");
  a_unmapped_zero: assert property (
    i_reg.rd && (i_reg.addr < 8'h08 || i_reg.addr > 8'h10) |=> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind rtcal_alarm rtcal_alarm_sva u_sva (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_reg(i_reg), .i_time_tick(i_time_tick),
  .i_clear_first_alarm_flag(i_clear_first_alarm_flag), .i_clear_second_alarm_flag(i_clear_second_alarm_flag),
  .i_irq_cfg(i_irq_cfg), .o_reg_rdata(o_reg_rdata), .o_first_alarm_flag(o_first_alarm_flag),
  .o_second_alarm_flag(o_second_alarm_flag), .o_irq_out_primary(o_irq_out_primary),
  .o_irq_out_secondary(o_irq_out_secondary));

// >>> test/rtcal_time_src.sv
`timescale 1ns/1ps
module rtcal_time_src (
  input  wire logic                   i_ref_clk, // Clock
  input  wire logic                   i_go,      // Advance request
  input  wire rtcal_pkg::rtcal_time_t i_next,    // Time to advance to
  output rtcal_pkg::rtcal_time_t      o_time,    // Counting time
  output logic                        o_tick     // Advanced this cycle
);
  // Time and tick move together, as the counters would
  always_ff @(posedge i_ref_clk) begin
    o_tick <= i_go;
    if (i_go) begin
      o_time <= i_next;
    end
  end
endmodule

// >>> test/tb.sv
`timescale 1ns/1ps
module tb;
  logic                     clk = 0, rst = 1, go = 0, mode = 0, c1 = 0, c2 = 0, f1, f2, ia, ib, tick;
  logic [7:0]               rdata;
  rtcal_pkg::rtcal_regreq_t rq = '0;
  rtcal_pkg::rtcal_time_t   nt = '0, tm;
  rtcal_pkg::rtcal_irqcfg_t cfg = 6'b0_01_1_10;
  int                       n_mismatch = 0, check_count = 0;
  logic [7:0]               mask [9] = '{8'h7F, 8'h7F, 8'h3F, 8'h3F, 8'h1F, 8'h7F, 8'h3F, 8'h07, 8'hFF};
  rtcal_alarm dut (.i_ref_clk(clk), .i_rst(rst), .i_reg(rq), .i_time_tick(tick), .i_time(tm),
    .i_counter_mode_select(mode), .i_clear_first_alarm_flag(c1), .i_clear_second_alarm_flag(c2),
    .i_irq_cfg(cfg), .o_reg_rdata(rdata), .o_first_alarm_flag(f1), .o_second_alarm_flag(f2),
    .o_irq_out_primary(ia), .o_irq_out_secondary(ib));
  rtcal_time_src u_src (.i_ref_clk(clk), .i_go(go), .i_next(nt), .o_time(tm), .o_tick(tick));
  initial forever #2.5 clk = ~clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) rq <= {1'b1, 1'b0, a, d};
    @(posedge clk) rq <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) rq <= {1'b0, 1'b1, a, 8'h00};
    @(posedge clk) rq <= '0;
    #1 chk(rdata, e);
  endtask
  // Expected bits: pulse irq, flag 2, flag 1; level irq A mirrors flag 1
  task automatic fl(input logic [2:0] e);
    chk({4'h0, ib, ia, f2, f1}, {4'h0, e[2], e[0], e[1:0]});
  endtask
  function automatic rtcal_pkg::rtcal_time_t mt(input logic [7:0] s, input logic [7:0] m);
    return {s, m, 8'h12, 8'h01, 8'h01, 8'h03, 24'h0};
  endfunction
  // Advance the time once; returns just after the edge that shows the flags
  task automatic adv(input rtcal_pkg::rtcal_time_t t);
    @(posedge clk) begin
      nt <= t;
      go <= 1'b1;
    end
    @(posedge clk) go <= 1'b0;
    @(posedge clk) #1;
  endtask
  task automatic tk(input rtcal_pkg::rtcal_time_t t, input logic [2:0] e);
    adv(t);
    fl(e);
  endtask
  task automatic cl(input logic [1:0] c, input logic [2:0] e);
    @(posedge clk) {c2, c1} <= c;
    @(posedge clk) {c2, c1} <= 2'b00;
    #1 fl(e);
  endtask
  task automatic t_reset();
    rd(8'h10, 8'h00);
    rd(8'h0D, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_regs();
    for (int i = 0; i < 9; i++) begin
      wr(8'(8 + i), 8'hFF);
      rd(8'(8 + i), mask[i]);
    end
    wr(8'h20, 8'hFF);
    rd(8'h20, 8'h00);
    @(posedge clk) mode <= 1'b1;
    wr(8'h0C, 8'h99);
    rd(8'h0C, 8'h99);
    wr(8'h0F, 8'h99);
    rd(8'h0F, 8'h99);
    @(posedge clk) mode <= 1'b0;
    rd(8'h0F, 8'h01);
    $display("test regs done");
  endtask
  task automatic t_alarm2();
    wr(8'h0D, 8'h30);
    wr(8'h0E, 8'h12);
    wr(8'h0F, 8'h03);
    wr(8'h10, 8'hE0);
    tk(mt(8'h00, 8'h30), 3'b110);
    tk(mt(8'h01, 8'h30), 3'b010);
    cl(2'b10, 3'b000);
    tk(mt(8'h02, 8'h30), 3'b000);
    tk(mt(8'h00, 8'h31), 3'b000);
    tk(mt(8'h00, 8'h30), 3'b110);
    cl(2'b11, 3'b000);
    $display("test alarm2 done");
  endtask
  task automatic t_alarm1();
    wr(8'h08, 8'h45);
    wr(8'h09, 8'h30);
    wr(8'h10, 8'h02);
    tk(mt(8'h00, 8'h29), 3'b000);
    tk(mt(8'h00, 8'h30), 3'b001);
    cl(2'b01, 3'b000);
    wr(8'h10, 8'h03);
    tk(mt(8'h00, 8'h30), 3'b000);
    tk(mt(8'h45, 8'h30), 3'b001);
    $display("test alarm1 done");
  endtask
  // Stop-watch hours matching, repeated pulse with flags set, then swapped irq modes
  task automatic t_stopwatch();
    rtcal_pkg::rtcal_time_t sw_hit;
    sw_hit             = '0;
    sw_hit.hr_hundreds = 8'h34;
    sw_hit.hr_tthous   = 8'h12;
    cl(2'b01, 3'b000);
    @(posedge clk) mode <= 1'b1;
    wr(8'h0C, 8'h12);
    wr(8'h0F, 8'h34);
    wr(8'h10, 8'h90);
    tk('0, 3'b000);
    tk(sw_hit, 3'b111);
    tk('0, 3'b011);
    tk(sw_hit, 3'b111);
    @(posedge clk) cfg <= 6'b1_01_0_10;
    @(posedge clk) #1 chk({6'h00, ib, ia}, 8'h02);
    adv('0);
    adv(sw_hit);
    chk({6'h00, ib, ia}, 8'h03);
    @(posedge clk) #1 chk({6'h00, ib, ia}, 8'h02);
    $display("test stopwatch done");
  endtask
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_alarm2();
    t_alarm1();
    t_stopwatch();
    report_and_stop();
  end
  initial begin
    #20000;
    n_mismatch++;
    report_and_stop();
  end
endmodule
